// *** omwc_map.vh ***
// constants for the operating mode and wake control block
`ifndef OMWC_MAP_VH
`define OMWC_MAP_VH
`define OMWC_ADDR_MODE 2'h0
`define OMWC_ADDR_CTRL 2'h1
`define OMWC_ADDR_WAKE 2'h2
`define OMWC_ADDR_STAT 2'h3
`define OMWC_MODE_RST 8'h03
`define OMWC_CLKSEL_BIT 0
`define OMWC_IDLE_BIT 1
`define OMWC_FAST_BIT 4
`define OMWC_DIV_HI 7
`define OMWC_DIV_LO 5
`define OMWC_SYSON_BIT 7
`define OMWC_DIV_SLOW_MAX 3'h1
`define OMWC_XTAL_SETTLE 11'h400
`define OMWC_SLOW_SETTLE 2'h2
`define OMWC_DIV_W 6
`define OMWC_DIV_FULL 3'h0
`define OMWC_SRC_SLOW 1'b0
`define OMWC_SRC_HIGH 1'b1
`endif

// *** omwc_clkdiv.v ***
// high clock divider select and glitch-free source changeover
`timescale 1ns/1ns
module omwc_clkdiv (
    input wire clk_i,                // block clock
    input wire reset_n_i,            // synchronous reset, active low
    input wire want_high_i,          // requested source is the high clock
    input wire high_ready_i,         // high oscillator ready
    input wire low_ready_i,          // low oscillator ready
    input wire [2:0] div_sel_i,      // divider select
    input wire run_i,                // system clock allowed to run
    output reg src_high_o,           // source in use, 1 = high
    output reg sys_en_o              // system clock tick enable
);
`include "omwc_map.vh"
    reg [`OMWC_DIV_W-1:0] div_cnt;
    reg [`OMWC_DIV_W-1:0] div_mask;
    reg low_phase;

    // divide mask: 111 -> /2 ... 010 -> /64, other codes run undivided
    always @* begin
        case (div_sel_i)
            3'h2: div_mask = 6'h3f;
            3'h3: div_mask = 6'h1f;
            3'h4: div_mask = 6'h0f;
            3'h5: div_mask = 6'h07;
            3'h6: div_mask = 6'h03;
            3'h7: div_mask = 6'h01;
            default: div_mask = 6'h00;
        endcase
    end

    // source changes only at a divider boundary once target is ready
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            div_cnt <= 6'h00;
            low_phase <= 1'b0;
            src_high_o <= `OMWC_SRC_HIGH;
            sys_en_o <= 1'b0;
        end else begin
            div_cnt <= div_cnt + 6'h01;
            low_phase <= ~low_phase;
            if ((div_cnt & div_mask) == 6'h00) begin
                if (want_high_i && high_ready_i)
                    src_high_o <= `OMWC_SRC_HIGH;
                else if (!want_high_i && low_ready_i)
                    src_high_o <= `OMWC_SRC_SLOW;
            end
            if (!run_i)
                sys_en_o <= 1'b0;
            else if (src_high_o)
                sys_en_o <= ((div_cnt & div_mask) == div_mask);
            else
                sys_en_o <= low_phase;
        end
    end
endmodule

// *** omwc_core.v ***
// operating mode, halt entry, flags and wake-up control
`timescale 1ns/1ns
module omwc_core (
    input wire CLK_I,                // 100 MHz clock
    input wire RESET_N_I,            // synchronous reset, active low
    input wire [1:0] ADDR_I,         // register address
    input wire [7:0] WDATA_I,        // write data
    input wire WR_I,                 // write strobe
    input wire RD_I,                 // read strobe
    input wire HALT_I,               // halt instruction executes
    input wire WDT_CLR_I,            // watchdog clear instruction
    input wire WDT_EN_I,             // watchdog enabled
    input wire WDT_OVF_I,            // watchdog overflow
    input wire EXT_RST_I,            // external reset pin
    input wire [7:0] PORTA_I,        // port A pins
    input wire [7:0] IRQ_FLAG_I,     // interrupt request flags
    input wire [7:0] IRQ_EN_I,       // interrupt enables
    input wire STACK_FULL_I,         // stack has no free level
    input wire XTAL_SEL_I,           // high clock is the crystal
    input wire HIGH_OSC_TICK_I,      // high oscillator cycle
    output reg [7:0] RDATA_O,        // read data
    output reg SYS_CLK_EN_O,         // system clock enable
    output reg SRC_HIGH_O,           // system source is high clock
    output reg WDT_CLK_EN_O,         // watchdog clock running
    output reg TB_CLK_EN_O,          // time base clock running
    output reg SUB_CLK_EN_O,         // sub clock running
    output reg WDT_CLEAR_O,          // clear watchdog, pulse
    output reg CPU_HALTED_O,         // program halted
    output reg FULL_RESET_O,         // full system reset, pulse
    output reg WDT_RESET_O,          // watchdog reset of PC and SP, pulse
    output reg IRQ_TAKE_O,           // take interrupt response, pulse
    output reg POWER_DOWN_FLAG_O,    // power-down flag
    output reg TIMEOUT_FLAG_O        // timeout flag
);
`include "omwc_map.vh"
    localparam ST_RUN = 3'h0;
    localparam ST_DEEP = 3'h1;
    localparam ST_WATCH = 3'h2;
    localparam ST_STOP_IDLE = 3'h3;
    localparam ST_RUN_IDLE = 3'h4;

    reg [7:0] system_mode_register;
    reg sysclk_in_idle;
    reg [7:0] porta_wake_enable;
    reg [2:0] state;
    reg [2:0] next_state;
    reg [7:0] pa_s1, pa_s2, pa_s3;
    reg rst_s1, rst_s2, rst_s3;
    reg [7:0] irq_armed;
    reg [10:0] high_cnt;
    reg high_osc_ready_flag;
    reg [1:0] low_cnt;
    reg low_osc_ready_flag;
    reg fast_wake;
    wire high_low_clock_select;
    wire idle_on_halt;
    wire fast_wake_enable;
    wire [2:0] clock_divider_select;
    wire want_high;
    wire pa_wake;
    wire rst_wake;
    wire [7:0] irq_new;
    wire irq_wake;
    wire low_power;
    wire clk_src_high;
    wire clk_tick;
    wire wake;

    assign high_low_clock_select = system_mode_register[`OMWC_CLKSEL_BIT];
    assign idle_on_halt = system_mode_register[`OMWC_IDLE_BIT];
    assign fast_wake_enable = system_mode_register[`OMWC_FAST_BIT];
    assign clock_divider_select =
        system_mode_register[`OMWC_DIV_HI:`OMWC_DIV_LO];
    // high clock wanted unless slow divider chosen, or early fast wake
    assign want_high = (high_low_clock_select |
        (clock_divider_select > `OMWC_DIV_SLOW_MAX)) & ~fast_wake;
    assign low_power = (state != ST_RUN);
    // falling edges on enabled port A pins
    assign pa_wake = |(pa_s3 & ~pa_s2 & porta_wake_enable);
    assign rst_wake = rst_s3 & ~rst_s2;
    // only flags that rose while asleep may wake
    assign irq_new = IRQ_FLAG_I & irq_armed;
    assign irq_wake = |irq_new;
    assign wake = rst_wake | pa_wake | irq_wake | WDT_OVF_I;

    omwc_clkdiv u_clkdiv (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .want_high_i(want_high),
        .high_ready_i(high_osc_ready_flag),
        .low_ready_i(low_osc_ready_flag),
        .div_sel_i(high_low_clock_select ? `OMWC_DIV_FULL :
            clock_divider_select),
        .run_i(state == ST_RUN || state == ST_RUN_IDLE),
        .src_high_o(clk_src_high),
        .sys_en_o(clk_tick)
    );

    // pin synchronisers, third stage kept for edge detection
    always @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            pa_s1 <= 8'hff;
            pa_s2 <= 8'hff;
            pa_s3 <= 8'hff;
            rst_s1 <= 1'b1;
            rst_s2 <= 1'b1;
            rst_s3 <= 1'b1;
        end else begin
            pa_s1 <= PORTA_I;
            pa_s2 <= pa_s1;
            pa_s3 <= pa_s2;
            rst_s1 <= EXT_RST_I;
            rst_s2 <= rst_s1;
            rst_s3 <= rst_s2;
        end
    end

    // halt decode into one of four low-power modes
    always @* begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (HALT_I) begin
                    if (!idle_on_halt)
                        next_state = WDT_EN_I ? ST_WATCH : ST_DEEP;
                    else
                        next_state = sysclk_in_idle ? ST_RUN_IDLE :
                            ST_STOP_IDLE;
                end
            end
            ST_DEEP, ST_WATCH, ST_STOP_IDLE, ST_RUN_IDLE: begin
                if (wake)
                    next_state = ST_RUN;
            end
            default: next_state = ST_RUN;
        endcase
    end

    // register writes, mode state, flags and wake actions
    always @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            system_mode_register <= `OMWC_MODE_RST;
            sysclk_in_idle <= 1'b0;
            porta_wake_enable <= 8'h00;
            state <= ST_RUN;
            irq_armed <= 8'h00;
            fast_wake <= 1'b0;
            WDT_CLEAR_O <= 1'b0;
            FULL_RESET_O <= 1'b0;
            WDT_RESET_O <= 1'b0;
            IRQ_TAKE_O <= 1'b0;
            POWER_DOWN_FLAG_O <= 1'b0;
            TIMEOUT_FLAG_O <= 1'b0;
        end else begin
            state <= next_state;
            WDT_CLEAR_O <= 1'b0;
            FULL_RESET_O <= 1'b0;
            WDT_RESET_O <= 1'b0;
            IRQ_TAKE_O <= 1'b0;
            if (WR_I) begin
                case (ADDR_I)
                    `OMWC_ADDR_MODE: system_mode_register <= WDATA_I;
                    `OMWC_ADDR_CTRL:
                        sysclk_in_idle <= WDATA_I[`OMWC_SYSON_BIT];
                    `OMWC_ADDR_WAKE: porta_wake_enable <= WDATA_I;
                    default: ;
                endcase
            end
            if (WDT_CLR_I && !HALT_I) begin
                POWER_DOWN_FLAG_O <= 1'b0;
                WDT_CLEAR_O <= 1'b1;
            end
            if (state == ST_RUN && HALT_I) begin
                POWER_DOWN_FLAG_O <= 1'b1;
                TIMEOUT_FLAG_O <= 1'b0;
                WDT_CLEAR_O <= 1'b1;
                irq_armed <= ~IRQ_FLAG_I;
            end
            if (low_power && wake) begin
                if (rst_wake)
                    FULL_RESET_O <= 1'b1;
                else if (WDT_OVF_I) begin
                    TIMEOUT_FLAG_O <= 1'b1;
                    WDT_RESET_O <= 1'b1;
                end else if (!pa_wake &&
                        |(irq_new & IRQ_EN_I) && !STACK_FULL_I)
                    IRQ_TAKE_O <= 1'b1;
                // other cases resume after the halt, service deferred
                fast_wake <= (state == ST_WATCH) && XTAL_SEL_I &&
                    fast_wake_enable;
            end
            if (high_osc_ready_flag)
                fast_wake <= 1'b0;
        end
    end

    // oscillator ready flags
    always @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            high_cnt <= 11'h000;
            high_osc_ready_flag <= 1'b0;
            low_cnt <= 2'h0;
            low_osc_ready_flag <= 1'b0;
        end else begin
            // crystal keeps settling while a fast wake runs from slow clock
            if (state == ST_DEEP || state == ST_WATCH ||
                    state == ST_STOP_IDLE ||
                    (!want_high && !clk_src_high && !fast_wake)) begin
                high_cnt <= 11'h000;
                high_osc_ready_flag <= 1'b0;
            end else if (!XTAL_SEL_I) begin
                high_osc_ready_flag <= 1'b1;
            end else if (HIGH_OSC_TICK_I && !high_osc_ready_flag) begin
                high_cnt <= high_cnt + 11'h001;
                if (high_cnt == `OMWC_XTAL_SETTLE - 11'h001)
                    high_osc_ready_flag <= 1'b1;
            end
            if (state == ST_DEEP) begin
                low_cnt <= 2'h0;
                low_osc_ready_flag <= 1'b0;
            end else if (!low_osc_ready_flag) begin
                low_cnt <= low_cnt + 2'h1;
                if (low_cnt == `OMWC_SLOW_SETTLE - 2'h1)
                    low_osc_ready_flag <= 1'b1;
            end
        end
    end

    // clock gating outputs per mode and register read port
    always @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            RDATA_O <= 8'h00;
            SYS_CLK_EN_O <= 1'b0;
            SRC_HIGH_O <= `OMWC_SRC_HIGH;
            WDT_CLK_EN_O <= 1'b1;
            TB_CLK_EN_O <= 1'b1;
            SUB_CLK_EN_O <= 1'b1;
            CPU_HALTED_O <= 1'b0;
        end else begin
            SYS_CLK_EN_O <= clk_tick;
            SRC_HIGH_O <= clk_src_high;
            WDT_CLK_EN_O <= (state != ST_DEEP) && WDT_EN_I;
            TB_CLK_EN_O <= (state == ST_RUN) || (state == ST_STOP_IDLE) ||
                (state == ST_RUN_IDLE);
            SUB_CLK_EN_O <= (state != ST_DEEP);
            CPU_HALTED_O <= low_power;
            RDATA_O <= 8'h00;
            if (RD_I) begin
                case (ADDR_I)
                    `OMWC_ADDR_MODE: RDATA_O <= {system_mode_register[7:4],
                        low_osc_ready_flag, high_osc_ready_flag,
                        system_mode_register[1:0]};
                    `OMWC_ADDR_CTRL: RDATA_O <= {sysclk_in_idle, 7'h00};
                    `OMWC_ADDR_WAKE: RDATA_O <= porta_wake_enable;
                    `OMWC_ADDR_STAT: RDATA_O <= {3'h0, state,
                        TIMEOUT_FLAG_O, POWER_DOWN_FLAG_O};
                    default: RDATA_O <= 8'h00;
                endcase
            end
        end
    end
endmodule

// *** omwc_core_sva.sv ***
// assertions on the operating mode and wake control ports
`timescale 1ns/1ns
module omwc_core_sva (
    input wire CLK_I,             // clock
    input wire RESET_N_I,         // reset, active low
    input wire RD_I,              // read strobe
    input wire HALT_I,            // halt instruction
    input wire WDT_CLR_I,         // watchdog clear instruction
    input wire WDT_OVF_I,         // watchdog overflow
    input wire [7:0] RDATA_O,     // read data
    input wire WDT_CLEAR_O,       // watchdog clear pulse
    input wire CPU_HALTED_O,      // program halted
    input wire POWER_DOWN_FLAG_O, // power-down flag
    input wire TIMEOUT_FLAG_O,    // timeout flag
    input wire WDT_RESET_O        // watchdog reset pulse
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // halt taken while running
    a_halt_sets_flags: assert property (HALT_I && !CPU_HALTED_O |=>
        POWER_DOWN_FLAG_O && !TIMEOUT_FLAG_O) else $error("halt flags");
    a_halt_clears_wdt: assert property (HALT_I && !CPU_HALTED_O |=>
        WDT_CLEAR_O) else $error("no watchdog clear on halt");
    a_halt_stops_cpu: assert property (HALT_I && !CPU_HALTED_O |->
        ##2 CPU_HALTED_O) else $error("program not halted");
    // power-down flag changes only by halt or watchdog clear
    a_clr_drops_pdn: assert property (WDT_CLR_I && !HALT_I &&
        !CPU_HALTED_O |=> !POWER_DOWN_FLAG_O)
        else $error("power-down flag not cleared");
    a_pdn_holds: assert property (!HALT_I && !WDT_CLR_I |=>
        $stable(POWER_DOWN_FLAG_O)) else $error("power-down flag changed");
    // watchdog overflow while halted
    a_ovf_timeout: assert property (CPU_HALTED_O && WDT_OVF_I |=>
        TIMEOUT_FLAG_O && WDT_RESET_O) else $error("overflow ignored");
    a_timeout_cause: assert property ($rose(TIMEOUT_FLAG_O) |->
        $past(WDT_OVF_I)) else $error("timeout without overflow");
    // read data only after a read strobe
    a_read_idle: assert property (!RD_I |=> RDATA_O == 8'h00)
        else $error("read data without read");
endmodule
bind omwc_core omwc_core_sva chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
    .RD_I(RD_I), .HALT_I(HALT_I), .WDT_CLR_I(WDT_CLR_I),
    .WDT_OVF_I(WDT_OVF_I), .RDATA_O(RDATA_O), .WDT_CLEAR_O(WDT_CLEAR_O),
    .CPU_HALTED_O(CPU_HALTED_O), .POWER_DOWN_FLAG_O(POWER_DOWN_FLAG_O),
    .TIMEOUT_FLAG_O(TIMEOUT_FLAG_O), .WDT_RESET_O(WDT_RESET_O));

// *** testbench.sv ***
// self-checking bench for the operating mode and wake control block
`timescale 1ns/1ns
module testbench;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [1:0] addr = 2'h0;
    reg [7:0] wdata = 8'h00;
    reg wr = 1'b0, rd = 1'b0, halt = 1'b0, wclr = 1'b0, wen = 1'b0;
    reg ovf = 1'b0, ext = 1'b1, full = 1'b0, xtal = 1'b0, tick = 1'b0;
    reg [7:0] pa = 8'hff, flag = 8'h00, ien = 8'h01;
    wire [7:0] rdata;
    wire sys_en, src_high, wdt_ck, tb_ck, sub_ck, wclr_o, halted;
    wire frst, wrst, take, pdn, tof;
    integer fail_count = 0, cmp_count = 0, i, n, k, src, j;
    integer tk = 0, tk0 = 0;
    reg [7:0] v, w;
    reg sf, sw, st;

    omwc_core dut (.CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .HALT_I(halt),
        .WDT_CLR_I(wclr), .WDT_EN_I(wen), .WDT_OVF_I(ovf), .EXT_RST_I(ext),
        .PORTA_I(pa), .IRQ_FLAG_I(flag), .IRQ_EN_I(ien),
        .STACK_FULL_I(full), .XTAL_SEL_I(xtal), .HIGH_OSC_TICK_I(tick),
        .RDATA_O(rdata), .SYS_CLK_EN_O(sys_en), .SRC_HIGH_O(src_high),
        .WDT_CLK_EN_O(wdt_ck), .TB_CLK_EN_O(tb_ck), .SUB_CLK_EN_O(sub_ck),
        .WDT_CLEAR_O(wclr_o), .CPU_HALTED_O(halted), .FULL_RESET_O(frst),
        .WDT_RESET_O(wrst), .IRQ_TAKE_O(take), .POWER_DOWN_FLAG_O(pdn),
        .TIMEOUT_FLAG_O(tof));

    always #5 clk = ~clk;
    // high oscillator cycles arrive at random
    // tk counts the cycles that the block has sampled so far
    always @(posedge clk) begin
        tick <= ($urandom % 4) != 0;
        tk <= tk + tick;
    end

    task check(input [7:0] seen, input [7:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("CHECK FAILED at %0t: got %h want %h", $time,
                    seen, exp);
            end
        end
    endtask
    task wr_reg(input [1:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd_reg(input [1:0] a, output [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 d = rdata;
        end
    endtask
    task wrap_up;
        begin
            if (fail_count == 0 && cmp_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // source that a clock select and divider code ask for
    function exp_src(input hl, input [2:0] cks);
        exp_src = hl | (cks > 3'h1);
    endfunction

    // cut a hang short; the tests need about 2000 cycles
    initial begin
        #100000;
        fail_count = fail_count + 1;
        wrap_up;
    end

    initial begin
        v = $urandom(37);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(2'h0, w);
        check(w & 8'hf3, 8'h03);
        rd_reg(2'h3, w);
        check(w, 8'h00);
        // every divider code with a random clock select
        for (i = 0; i < 8; i = i + 1) begin
            j = $urandom % 2;
            v = {i[2:0], 4'h0, j[0]};
            wr_reg(2'h0, v);
            rd_reg(2'h0, w);
            check(w & 8'hf3, v);
            n = 0;
            while (src_high !== exp_src(v[0], v[7:5]) && n < 3000) begin
                @(posedge clk);
                #1 n = n + 1;
            end
            check(src_high, exp_src(v[0], v[7:5]));
        end
        // each low-power mode, woken by two of the four sources
        for (i = 0; i < 8; i = i + 1) begin
            k = i % 4 + 1;
            src = (i + (i / 4) * 2) % 4;
            j = $urandom % 8;
            wen <= (k != 1);
            full <= (i >= 4);
            xtal <= j[2];
            flag <= 8'h80;
            wr_reg(2'h0, (k >= 3) ? 8'h03 : 8'h01);
            wr_reg(2'h1, (k == 4) ? 8'h80 : 8'h00);
            wr_reg(2'h2, 8'h01 << j);
            @(posedge clk);
            wclr <= 1'b1;
            @(posedge clk);
            wclr <= 1'b0;
            #1 check(pdn, 1'b0);
            @(posedge clk);
            halt <= 1'b1;
            @(posedge clk);
            halt <= 1'b0;
            #1 check({pdn, tof, wclr_o}, 8'h05);
            @(posedge clk);
            #1 check(halted, 1'b1);
            repeat (3) @(posedge clk);
            #1 check({sys_en, tb_ck, wdt_ck, sub_ck | (k != 4)},
                {k == 4, k >= 3, k != 1, 1'b1});
            rd_reg(2'h3, w);
            check(w, {3'h0, k[2:0], 2'h1});
            // a disabled pin and a pre-set request must not wake
            @(posedge clk);
            pa <= ~(8'h01 << ((j + 1) % 8));
            repeat (8) @(posedge clk);
            #1 check(halted, 1'b1);
            @(posedge clk);
            case (src)
                0: ext <= 1'b0;
                1: ovf <= 1'b1;
                2: pa <= pa & ~(8'h01 << j);
                default: flag <= 8'h81;
            endcase
            sf = 1'b0;
            sw = 1'b0;
            st = 1'b0;
            for (n = 0; n < 12; n = n + 1) begin
                @(posedge clk);
                ovf <= 1'b0;
                #1 sf = sf | frst;
                sw = sw | wrst;
                st = st | take;
            end
            check(halted, 1'b0);
            check({sf, sw, st},
                {src == 0, src == 1, src == 3 && i < 4});
            check({tof, pdn}, {src == 1, 1'b1});
            @(posedge clk);
            ext <= 1'b1;
            pa <= 8'hff;
        end
        // fast wake from watch sleep runs slow until the crystal settles
        xtal <= 1'b1;
        wen <= 1'b1;
        wr_reg(2'h0, 8'h11);
        wr_reg(2'h1, 8'h00);
        @(posedge clk);
        halt <= 1'b1;
        @(posedge clk);
        halt <= 1'b0;
        repeat (3) @(posedge clk);
        ovf <= 1'b1;
        @(posedge clk);
        ovf <= 1'b0;
        #1 tk0 = tk;
        repeat (3) @(posedge clk);
        #1 check(src_high, 1'b0);
        // software polls the crystal ready flag before trusting it
        n = 0;
        w = 8'h00;
        while (w[2] !== 1'b1 && n < 1500) begin
            rd_reg(2'h0, w);
            n = n + 1;
            if (w[2] === 1'b1)
                check(tk - tk0 >= 1024, 1'b1);
            else
                check(tk - tk0 <= 1024, 1'b1);
        end
        check(w[2], 1'b1);
        repeat (4) @(posedge clk);
        #1 check(src_high, 1'b1);
        wrap_up;
    end
endmodule
